// [fmmc_params.svh]
`ifndef FMMC_PARAMS_SVH
`define FMMC_PARAMS_SVH
// ----------------------------------------
// Register map (byte addresses) and address window codes
// ----------------------------------------
`define FMMC_REG_CTRL 12'h000
`define FMMC_REG_STAT 12'h004
`define FMMC_REG_MAP 12'h008
`define FMMC_REG_CFG 12'h00C
`define FMMC_WIN_REG 2'h0
`define FMMC_WIN_IN 2'h1
`define FMMC_WIN_OUT 2'h2
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FMMC_CTRL_ODIS 0
`define FMMC_CTRL_RESTART 1
`define FMMC_OPT_ACKTO 0
// ----------------------------------------
// Configuration image layout
// ----------------------------------------
`define FMMC_CFG_NSLV 0
`define FMMC_CFG_ADDR 1
`define FMMC_CFG_BAUD 2
`define FMMC_CFG_OPT 3
`define FMMC_CFG_INW 4
`define FMMC_CFG_OUTW 5
`define FMMC_CFG_SUM 6
`define FMMC_CFG_LAST 3'h6
// ----------------------------------------
// Limits and defaults
// ----------------------------------------
`define FMMC_MAX_SLAVES 8'h7D
`define FMMC_IO_WORDS 8'h40
`define FMMC_DEF_ADDR 8'h01
`define FMMC_BAUD_1M5 8'h06
// ----------------------------------------
// Timing
// ----------------------------------------
`define FMMC_CLK_MHZ 100
`define FMMC_FILT_US 10000
`define FMMC_FILT_CYC (`FMMC_FILT_US * `FMMC_CLK_MHZ)
`define FMMC_CARD_NS 100
`define FMMC_CARD_CYC ((`FMMC_CARD_NS * `FMMC_CLK_MHZ + 999) / 1000)
`define FMMC_SETTLE 4'h3
`endif

// [fmmc_pkg.sv]
`default_nettype none
package fmmc_pkg;
    typedef enum logic [2:0] {
        M_PWR, M_LOAD, M_CHECK, M_STOP, M_LINK, M_RUN
    } fmmc_mode_t;

    typedef struct packed {
        fmmc_mode_t mode;
        logic sel_s1;
        logic sel_s2;
        logic sel_f;
        logic card_s1;
        logic card_s2;
        logic [7:0] cd_s1;
        logic [7:0] cd_s2;
        logic [19:0] filt_cnt;
        logic [2:0] cfg_idx;
        logic [3:0] wait_cnt;
        logic [6:0][7:0] cfg;
        logic cfg_bad;
        logic card_rd;
        logic odis;
        logic [7:0] map_in;
        logic [7:0] map_out;
        logic wait_r;
        logic [31:0] rdata;
        logic alarm;
        logic host_stop;
        logic fail_d;
        logic lamp_sup;
        logic lamp_flt;
        logic lamp_run;
        logic lamp_exch;
        logic out_zero;
        logic exch_en;
        logic bus_act;
        logic [7:0] bus_addr;
        logic [7:0] bus_baud;
    } fmmc_state_t;
endpackage : fmmc_pkg
`default_nettype wire

// [fmmc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fmmc_params.svh"

module fmmc_top
    import fmmc_pkg::*;
#(
    parameter int FILT_CYC = `FMMC_FILT_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Avalon-MM slave
    input wire logic [11:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Mode selector and memory card pins
    input wire logic SEL_RUN,
    input wire logic CARD_PRESENT,
    input wire logic [7:0] CARD_DATA,
    output logic CARD_RD,
    output logic [2:0] CARD_ADDR,
    // Fieldbus engine, same clock
    input wire logic LINK_UP,
    input wire logic SLV_FAIL,
    input wire logic SLV_ALL_DX,
    input wire logic SLV_ACTIVE,
    input wire logic SLV_ACK_TO,
    input wire logic FB_IN_WE,
    input wire logic [5:0] FB_IN_ADDR,
    input wire logic [31:0] FB_IN_DATA,
    input wire logic [5:0] FB_OUT_ADDR,
    output logic [31:0] FB_OUT_DATA,
    output logic BUS_ACTIVE,
    output logic EXCH_EN,
    output logic [7:0] BUS_ADDR,
    output logic [7:0] BUS_BAUD,
    output logic [7:0] BUS_SLAVES,
    // Lamps
    output logic SUPPLY_LAMP,
    output logic FAULT_LAMP,
    output logic RUN_LAMP,
    output logic EXCHANGE_LAMP,
    output logic CONFIG_FAULT_LAMP,
    // Host events
    output logic ALARM,
    output logic HOST_STOP
);

    // ----------------------------------------
    // State and memories
    // ----------------------------------------
    fmmc_state_t s;
    fmmc_state_t n;
    logic [31:0] in_mem [0:63];
    logic [31:0] out_mem [0:63];
    logic [31:0] fbo_r;
    logic take;
    logic done;
    logic wr_out;
    logic sel_rise;
    logic [31:0] rd_nxt;

    function automatic logic cfg_ok(input logic [6:0][7:0] c);
        logic [7:0] sum;
        sum = c[`FMMC_CFG_NSLV] + c[`FMMC_CFG_ADDR] + c[`FMMC_CFG_BAUD]
            + c[`FMMC_CFG_OPT] + c[`FMMC_CFG_INW] + c[`FMMC_CFG_OUTW];
        // Checksum, then slave count, address and I/O word limits
        // count check
        return (sum == c[`FMMC_CFG_SUM])
            && (c[`FMMC_CFG_NSLV] != 8'h00)
            && (c[`FMMC_CFG_NSLV] <= `FMMC_MAX_SLAVES)
            && (c[`FMMC_CFG_ADDR] <= `FMMC_MAX_SLAVES)
            && (c[`FMMC_CFG_INW] <= `FMMC_IO_WORDS)
            && (c[`FMMC_CFG_OUTW] <= `FMMC_IO_WORDS);
    endfunction : cfg_ok

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign take = (AVS_READ || AVS_WRITE) && s.wait_r;
    // Writes land on the edge that sees waitrequest low, as the master expects
    assign done = (AVS_READ || AVS_WRITE) && !s.wait_r;
    assign wr_out = done && AVS_WRITE && (AVS_ADDRESS[11:10] == `FMMC_WIN_OUT);

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (AVS_ADDRESS[11:10])
            `FMMC_WIN_IN: begin
                rd_nxt = in_mem[AVS_ADDRESS[7:2]];
            end
            `FMMC_WIN_OUT: begin
                rd_nxt = out_mem[AVS_ADDRESS[7:2]];
            end
            `FMMC_WIN_REG: begin
                if (AVS_ADDRESS == `FMMC_REG_CTRL) begin
                    rd_nxt = {31'h0000_0000, s.odis};
                end else if (AVS_ADDRESS == `FMMC_REG_STAT) begin
                    rd_nxt = {21'h00_0000, s.alarm, s.bus_act, s.out_zero, s.lamp_exch,
                        s.lamp_run, s.lamp_flt, s.lamp_sup, s.cfg_bad, s.mode};
                end else if (AVS_ADDRESS == `FMMC_REG_MAP) begin
                    rd_nxt = {16'h0000, s.map_out, s.map_in};
                end else if (AVS_ADDRESS == `FMMC_REG_CFG) begin
                    rd_nxt = {8'h00, s.bus_baud, s.bus_addr, s.cfg[`FMMC_CFG_NSLV]};
                end
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = s;
        n.alarm = 1'b0;
        n.host_stop = 1'b0;
        n.sel_s1 = SEL_RUN;
        n.sel_s2 = s.sel_s1;
        n.card_s1 = CARD_PRESENT;
        n.card_s2 = s.card_s1;
        n.cd_s1 = CARD_DATA;
        n.cd_s2 = s.cd_s1;
        n.fail_d = SLV_FAIL;
        // Filter so contact bounce gives one change
        // selector filter
        if (s.sel_s2 != s.sel_f) begin
            if (s.filt_cnt == 20'(FILT_CYC - 1)) begin
                n.sel_f = s.sel_s2;
                n.filt_cnt = 20'h0_0000;
            end else begin
                n.filt_cnt = s.filt_cnt + 20'h0_0001;
            end
        end else begin
            n.filt_cnt = 20'h0_0000;
        end
        sel_rise = n.sel_f && !s.sel_f;
        // Bus slave: one wait-free cycle per access
        n.wait_r = !take;
        if (take) begin
            n.rdata = rd_nxt;
        end
        if (done && AVS_WRITE && AVS_ADDRESS == `FMMC_REG_CTRL && AVS_BYTEENABLE[0]) begin
            n.odis = AVS_WRITEDATA[`FMMC_CTRL_ODIS];
            if (AVS_WRITEDATA[`FMMC_CTRL_RESTART]) begin
                n.map_in = s.cfg_bad ? 8'h00 : s.cfg[`FMMC_CFG_INW];
                n.map_out = s.cfg_bad ? 8'h00 : s.cfg[`FMMC_CFG_OUTW];
            end
        end
        case (s.mode)
            M_PWR: begin
                // Let the pin synchronisers settle first
                if (s.wait_cnt != `FMMC_SETTLE) begin
                    n.wait_cnt = s.wait_cnt + 4'h1;
                end else if (s.card_s2) begin
                    n.mode = M_LOAD;
                    n.wait_cnt = 4'h0;
                    n.cfg_idx = 3'h0;
                    n.card_rd = 1'b1;
                end else begin
                    n.mode = M_STOP;
                    n.cfg_bad = 1'b1;
                    n.bus_addr = `FMMC_DEF_ADDR;
                    n.bus_baud = `FMMC_BAUD_1M5;
                end
            end
            M_LOAD: begin
                // Card read time includes synchroniser delay
                if (s.wait_cnt == 4'(`FMMC_CARD_CYC - 1)) begin
                    n.cfg[s.cfg_idx] = s.cd_s2;
                    n.wait_cnt = 4'h0;
                    if (s.cfg_idx == `FMMC_CFG_LAST) begin
                        n.card_rd = 1'b0;
                        n.mode = M_CHECK;
                    end else begin
                        n.cfg_idx = s.cfg_idx + 3'h1;
                    end
                end else begin
                    n.wait_cnt = s.wait_cnt + 4'h1;
                end
            end
            M_CHECK: begin
                if (cfg_ok(s.cfg)) begin
                    n.cfg_bad = 1'b0;
                    n.bus_addr = s.cfg[`FMMC_CFG_ADDR];
                    n.bus_baud = s.cfg[`FMMC_CFG_BAUD];
                    n.mode = s.sel_f ? M_LINK : M_STOP;
                end else begin
                    n.cfg_bad = 1'b1;
                    n.bus_addr = `FMMC_DEF_ADDR;
                    n.bus_baud = `FMMC_BAUD_1M5;
                    n.mode = M_STOP;
                end
            end
            M_STOP: begin
                // Card pin is not looked at here
                // card ignored
                if (sel_rise) begin
                    n.mode = M_LOAD;
                    n.wait_cnt = 4'h0;
                    n.cfg_idx = 3'h0;
                    n.card_rd = 1'b1;
                end
            end
            M_LINK: begin
                if (!n.sel_f) begin
                    n.mode = M_STOP;
                    n.alarm = 1'b1;
                end else if (LINK_UP) begin
                    n.mode = M_RUN;
                end
            end
            M_RUN: begin
                if (!n.sel_f) begin
                    n.mode = M_STOP;
                    n.alarm = 1'b1;
                end else if (SLV_FAIL && !s.fail_d) begin
                    n.alarm = 1'b1;
                end
                if (SLV_ACK_TO && s.cfg[`FMMC_CFG_OPT][`FMMC_OPT_ACKTO]) begin
                    n.host_stop = 1'b1;
                end
            end
            default: begin
                n.mode = M_PWR;
            end
        endcase
        if (n.alarm && s.cfg[`FMMC_CFG_OPT][`FMMC_OPT_ACKTO]) begin
            n.host_stop = 1'b1;
        end
        // Lamps and output gating follow the new mode
        n.lamp_sup = 1'b1;
        n.lamp_run = (n.mode == M_LINK) || (n.mode == M_RUN);
        n.lamp_exch = (n.mode == M_RUN) && SLV_ACTIVE;
        n.lamp_flt = SLV_FAIL || ((n.mode == M_RUN) && !SLV_ALL_DX);
        n.bus_act = (n.mode == M_STOP) || (n.mode == M_LINK) || (n.mode == M_RUN);
        n.exch_en = (n.mode == M_RUN);
        n.out_zero = (n.mode != M_RUN) || n.odis;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            s <= '0;
            s.mode <= M_PWR;
            s.wait_r <= 1'b1;
            s.out_zero <= 1'b1;
            s.bus_addr <= `FMMC_DEF_ADDR;
            s.bus_baud <= `FMMC_BAUD_1M5;
        end else begin
            s <= n;
        end
    end

    // Memories carry no reset; unread areas are don't-care
    always_ff @(posedge CLK_SYS) begin
        if (FB_IN_WE && s.exch_en) begin
            in_mem[FB_IN_ADDR] <= FB_IN_DATA;
        end
        if (wr_out) begin
            for (int b = 0; b < 4; b++) begin
                if (AVS_BYTEENABLE[b]) begin
                    out_mem[AVS_ADDRESS[7:2]][b*8 +: 8] <= AVS_WRITEDATA[b*8 +: 8];
                end
            end
        end
        if (!RST_N || s.out_zero) begin
            fbo_r <= 32'h0000_0000;
        end else begin
            fbo_r <= out_mem[FB_OUT_ADDR];
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign AVS_READDATA = s.rdata;
    assign AVS_WAITREQUEST = s.wait_r;
    assign CARD_RD = s.card_rd;
    assign CARD_ADDR = s.cfg_idx;
    assign FB_OUT_DATA = fbo_r;
    assign BUS_ACTIVE = s.bus_act;
    assign EXCH_EN = s.exch_en;
    assign BUS_ADDR = s.bus_addr;
    assign BUS_BAUD = s.bus_baud;
    assign BUS_SLAVES = s.cfg_bad ? 8'h00 : s.cfg[`FMMC_CFG_NSLV];
    assign SUPPLY_LAMP = s.lamp_sup;
    assign FAULT_LAMP = s.lamp_flt;
    assign RUN_LAMP = s.lamp_run;
    assign EXCHANGE_LAMP = s.lamp_exch;
    assign CONFIG_FAULT_LAMP = s.cfg_bad;
    assign ALARM = s.alarm;
    assign HOST_STOP = s.host_stop;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence seq_run_left;
        (s.mode == M_RUN) ##1 (s.mode == M_STOP);
    endsequence
    sequence seq_bad_check;
        (s.mode == M_CHECK) && !cfg_ok(s.cfg);
    endsequence

    AST_STOP_ALARM: assert property (seq_run_left |-> s.alarm)
        else $error("no alarm on run to stop");
    AST_ZERO_OFF_RUN: assert property ((s.mode != M_RUN) |=> (fbo_r == 32'h0000_0000))
        else $error("outputs not zero outside run");
    AST_ODIS_ZERO: assert property ($rose(s.odis) |-> ##[1:2] (fbo_r == 32'h0000_0000))
        else $error("output disable ignored");
    AST_BAD_DEFAULT: assert property (seq_bad_check |=>
        (s.mode == M_STOP) && s.cfg_bad && (s.bus_addr == `FMMC_DEF_ADDR))
        else $error("bad image not defaulted");
    AST_EXCH_RUN: assert property (s.lamp_exch |-> (s.mode == M_RUN) && s.lamp_run)
        else $error("exchange lamp outside run");
    AST_LINK_LAMP: assert property ((s.mode == M_LINK) |-> s.lamp_run && !s.lamp_exch)
        else $error("link lamps wrong");
    AST_BUS_ONE: assert property (take |=> !s.wait_r ##1 s.wait_r)
        else $error("bus answer timing wrong");
    AST_FILTER: assert property ($changed(s.sel_f) |->
        ($past(s.filt_cnt) == 20'(FILT_CYC - 1)))
        else $error("selector change not filtered");
    AST_RISE_LOAD: assert property (($rose(s.sel_f) && ($past(s.mode) == M_STOP))
        |-> (s.mode == M_LOAD))
        else $error("no reload on stop to run");
    AST_LOAD_END: assert property ($rose(s.mode == M_LOAD) |-> ##[60:80] (s.mode == M_CHECK))
        else $error("load did not reach check");
    AST_ACKTO_OPT: assert property (s.host_stop |->
        $past(s.cfg[`FMMC_CFG_OPT][`FMMC_OPT_ACKTO]))
        else $error("host stop without option");

endmodule : fmmc_top
`default_nettype wire

// [fmmc_card_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Memory card partner
// ----------------------------------------
module fmmc_card_model
    import fmmc_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Card pins
    input wire logic card_rd,
    input wire logic [2:0] card_addr,
    input wire logic present,
    input wire logic [6:0][7:0] image,
    output logic [7:0] card_data
);
    logic [7:0] last_r = 8'h00;
    logic [7:0] byte_w;
    logic drive_w;
    // Out of range index never reads as valid data
    assign byte_w = (card_addr <= 3'h6) ? image[card_addr] : ~last_r;
    assign drive_w = card_rd && present;
    always_ff @(posedge clk_sys) begin
        if (drive_w) begin
            last_r <= byte_w;
        end
    end
    // image served on read
    // Released lines show the inverse, so stale data cannot pass
    assign card_data = drive_w ? byte_w : ~last_r;
endmodule : fmmc_card_model
`default_nettype wire

// [fmmc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fmmc_params.svh"
module fmmc_top_bench
    import fmmc_pkg::*;
;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} fmmc_row_t;
    logic CLK_SYS = 1'b0;
    logic RST_N = 1'b0;
    logic [11:0] AVS_ADDRESS = 12'h000;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic SEL_RUN = 1'b1;
    logic CARD_PRESENT = 1'b1;
    logic [7:0] CARD_DATA;
    logic CARD_RD;
    logic [2:0] CARD_ADDR;
    logic LINK_UP = 1'b0, SLV_FAIL = 1'b0, SLV_ALL_DX = 1'b0, SLV_ACTIVE = 1'b0, SLV_ACK_TO = 1'b0;
    logic FB_IN_WE = 1'b0;
    logic [5:0] FB_IN_ADDR = 6'h00, FB_OUT_ADDR = 6'h00;
    logic [31:0] FB_IN_DATA = 32'h0, FB_OUT_DATA;
    logic BUS_ACTIVE, EXCH_EN, SUPPLY_LAMP, FAULT_LAMP, RUN_LAMP, EXCHANGE_LAMP, CONFIG_FAULT_LAMP;
    logic ALARM, HOST_STOP;
    logic [7:0] BUS_ADDR, BUS_BAUD, BUS_SLAVES;
    logic [6:0][7:0] img;
    logic [31:0] rd;
    logic rd_d = 1'b0;
    fmmc_row_t rows [8];
    int miscompares = 0, n_checks = 0, cycles = 0, n_alarm = 0, n_hs = 0, n_load = 0, a0, h0;

    fmmc_top #(.FILT_CYC(4)) fmmc_top_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .SEL_RUN(SEL_RUN), .CARD_PRESENT(CARD_PRESENT),
        .CARD_DATA(CARD_DATA), .CARD_RD(CARD_RD), .CARD_ADDR(CARD_ADDR), .LINK_UP(LINK_UP),
        .SLV_FAIL(SLV_FAIL), .SLV_ALL_DX(SLV_ALL_DX), .SLV_ACTIVE(SLV_ACTIVE), .SLV_ACK_TO(SLV_ACK_TO),
        .FB_IN_WE(FB_IN_WE), .FB_IN_ADDR(FB_IN_ADDR), .FB_IN_DATA(FB_IN_DATA), .FB_OUT_ADDR(FB_OUT_ADDR),
        .FB_OUT_DATA(FB_OUT_DATA), .BUS_ACTIVE(BUS_ACTIVE), .EXCH_EN(EXCH_EN), .BUS_ADDR(BUS_ADDR),
        .BUS_BAUD(BUS_BAUD), .BUS_SLAVES(BUS_SLAVES), .SUPPLY_LAMP(SUPPLY_LAMP), .FAULT_LAMP(FAULT_LAMP),
        .RUN_LAMP(RUN_LAMP), .EXCHANGE_LAMP(EXCHANGE_LAMP), .CONFIG_FAULT_LAMP(CONFIG_FAULT_LAMP),
        .ALARM(ALARM), .HOST_STOP(HOST_STOP));
    fmmc_card_model fmmc_card_model_inst (.clk_sys(CLK_SYS), .card_rd(CARD_RD), .card_addr(CARD_ADDR),
        .present(CARD_PRESENT), .image(img), .card_data(CARD_DATA));

    always #5 CLK_SYS = ~CLK_SYS;
    // ----------------------------------------
    // Event counters and timeout
    // ----------------------------------------
    always @(posedge CLK_SYS) begin
        n_alarm += (ALARM === 1'b1);
        n_hs += (HOST_STOP === 1'b1);
        n_load += (CARD_RD === 1'b1 && rd_d === 1'b0);
        rd_d = CARD_RD;
        cycles++;
        // Whole run needs a few hundred cycles
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask : cyc
    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        @(posedge CLK_SYS);
        while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK_SYS);
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLK_SYS);
    endtask : bus
    task automatic mode_wait(input logic [2:0] m);
        int i;
        for (i = 0; i < 400; i++) begin
            bus(1'b0, `FMMC_REG_STAT, 32'h0, rd);
            if (rd[2:0] === m) break;
        end
        chk(rd[2:0], m);
    endtask : mode_wait
    function automatic logic [7:0] csum(input logic [6:0][7:0] im);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 6; i++) s += im[i];
        return s;
    endfunction : csum
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        img[5:0] = 48'h0202_0103_0503;
        img[6] = csum(img);
        rows = '{'{12'h000, 32'h2, 32'h0}, '{12'h008, 32'hFFFFFFFF, 32'h0202},
            '{12'h00C, 32'h0, 32'h00030503}, '{12'h010, 32'hFFFFFFFF, 32'h0},
            '{12'h404, 32'hFFFFFFFF, 32'h12345678}, '{12'h804, 32'hCAFEF00D, 32'hCAFEF00D},
            '{12'h8FC, 32'h0000BEEF, 32'h0000BEEF}, '{12'hC00, 32'hFFFFFFFF, 32'h0}};
        cyc(2);
        chk(AVS_WAITREQUEST, 1'b1);
        chk({RUN_LAMP, FAULT_LAMP, EXCHANGE_LAMP, CONFIG_FAULT_LAMP}, 4'h0);
        chk({BUS_ADDR, BUS_BAUD, FB_OUT_DATA}, {8'h01, 8'h06, 32'h0});
        cyc(1);
        RST_N <= 1'b1;
        cyc(3);
        chk(SUPPLY_LAMP, 1'b1);
        $display("reset test done");
        mode_wait(M_LINK);
        chk({RUN_LAMP, EXCHANGE_LAMP}, 2'b10);
        chk(n_load, 1);
        chk({BUS_SLAVES, BUS_ADDR, BUS_BAUD}, 24'h030503);
        bus(1'b1, 12'h800, 32'h11223344, rd);
        cyc(2);
        chk(FB_OUT_DATA, 32'h0);
        LINK_UP <= 1'b1;
        SLV_ACTIVE <= 1'b1;
        mode_wait(M_RUN);
        cyc(2);
        chk({RUN_LAMP, EXCHANGE_LAMP, FAULT_LAMP, EXCH_EN}, 4'hF);
        chk(FB_OUT_DATA, 32'h11223344);
        SLV_ALL_DX <= 1'b1;
        cyc(3);
        chk(FAULT_LAMP, 1'b0);
        $display("power-on run test done");
        FB_IN_ADDR <= 6'h01;
        FB_IN_DATA <= 32'h12345678;
        FB_IN_WE <= 1'b1;
        cyc(1);
        FB_IN_WE <= 1'b0;
        cyc(1);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d, rd);
            bus(1'b0, rows[i].a, 32'h0, rd);
            chk(rd, rows[i].e);
        end
        $display("register table test done");
        bus(1'b1, `FMMC_REG_CTRL, 32'h1, rd);
        cyc(2);
        chk(FB_OUT_DATA, 32'h0);
        bus(1'b1, `FMMC_REG_CTRL, 32'h0, rd);
        CARD_PRESENT <= 1'b0;
        cyc(10);
        mode_wait(M_RUN);
        CARD_PRESENT <= 1'b1;
        a0 = n_alarm;
        h0 = n_hs;
        SLV_FAIL <= 1'b1;
        cyc(3);
        chk(FAULT_LAMP, 1'b1);
        chk(n_alarm, a0 + 1);
        chk(n_hs, h0 + 1);
        SLV_FAIL <= 1'b0;
        SLV_ACK_TO <= 1'b1;
        cyc(1);
        SLV_ACK_TO <= 1'b0;
        cyc(3);
        chk(n_hs, h0 + 2);
        $display("fault and disable test done");
        SEL_RUN <= 1'b0;
        cyc(2);
        SEL_RUN <= 1'b1;
        cyc(10);
        mode_wait(M_RUN);
        chk(n_load, 1);
        a0 = n_alarm;
        SEL_RUN <= 1'b0;
        mode_wait(M_STOP);
        cyc(2);
        chk(n_alarm, a0 + 1);
        chk({RUN_LAMP, EXCH_EN, BUS_ACTIVE, FB_OUT_DATA}, {3'b001, 32'h0});
        chk(BUS_ADDR, 8'h05);
        $display("stop test done");
        img[6] = img[6] ^ 8'h01;
        SEL_RUN <= 1'b1;
        cyc(20);
        mode_wait(M_STOP);
        chk(n_load, 2);
        chk({CONFIG_FAULT_LAMP, rd[3], BUS_ADDR, BUS_BAUD}, {2'b11, 8'h01, 8'h06});
        SEL_RUN <= 1'b0;
        img[3] = 8'h00;
        img[6] = csum(img);
        cyc(12);
        SEL_RUN <= 1'b1;
        cyc(20);
        mode_wait(M_RUN);
        chk(CONFIG_FAULT_LAMP, 1'b0);
        h0 = n_hs;
        SLV_ACK_TO <= 1'b1;
        cyc(1);
        SLV_ACK_TO <= 1'b0;
        cyc(3);
        chk(n_hs, h0);
        $display("reload test done");
        RST_N <= 1'b0;
        CARD_PRESENT <= 1'b0;
        cyc(3);
        RST_N <= 1'b1;
        mode_wait(M_STOP);
        cyc(2);
        chk({CONFIG_FAULT_LAMP, BUS_ADDR, BUS_BAUD}, {1'b1, 8'h01, 8'h06});
        $display("no card test done");
        close_out();
    end
endmodule : fmmc_top_bench
`default_nettype wire
